// ### rtl/four_channel_bridge_dma.sv
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module four_channel_bridge_dma
	import four_channel_bridge_dma_pkg::*;
(
	// Clock and reset.
	input  wire logic                     CLK_SYS,
	input  wire logic                     RSTN,
	// Avalon-MM register slave.
	input  wire logic [AV_AW-1:0]         AVS_ADDRESS,
	input  wire logic                     AVS_READ,
	input  wire logic                     AVS_WRITE,
	input  wire logic [31:0]              AVS_WRITEDATA,
	output logic      [31:0]              AVS_READDATA,
	output logic                          AVS_WAITREQUEST,
	// Request sources and acknowledges.
	input  wire logic [N_CH*N_SRC-1:0]    HW_REQ,
	input  wire logic [N_EXT-1:0]         XREQ_N,
	output logic      [N_EXT-1:0]         XACK_N,
	output logic      [N_CH-1:0]          ACK,
	output logic      [N_CH-1:0]          INT_REQ,
	// Data mover bus master.
	output logic                          BUS_REQ,
	input  wire logic                     BUS_GNT,
	output logic      [31:0]              M_ADDR,
	output logic                          M_LOC,
	output logic      [1:0]               M_SIZE,
	output logic                          M_READ,
	output logic                          M_WRITE,
	output logic      [31:0]              M_WDATA,
	input  wire logic [31:0]              M_RDATA,
	input  wire logic                     M_WAIT
);

	// Byte address of beat n from a base address.
	function automatic logic [31:0] beat_addr(input logic [ADDR_W-1:0] base,
		input logic [1:0] n, input logic [1:0] ds);
		return {1'b0, base + (ADDR_W'(n) << ds)};
	endfunction : beat_addr

	// Bytes moved by one whole chunk.
	function automatic logic [ADDR_W-1:0] chunk_bytes(input logic [31:0] cw);
		return (cw[CW_BURST] ? ADDR_W'(BURST_LEN) : ADDR_W'(1)) << cw[CW_DSIZE +: 2];
	endfunction : chunk_bytes

	logic                 rst_meta_ff;         // First reset stage.
	logic                 rst_n_ff;            // Released reset copy.
	logic [N_EXT-1:0]     xreq_meta_ff;        // First request stage.
	logic [N_EXT-1:0]     xreq_sync_ff;        // Synchronised request, low active.
	logic                 wait_ff;             // Slave waitrequest.
	logic [31:0]          rdata_ff;            // Slave read data.
	logic [ADDR_W-1:0]    src_start_ff [N_CH]; // Programmed source.
	logic [ADDR_W-1:0]    dst_start_ff [N_CH]; // Programmed destination.
	logic [ADDR_W-1:0]    cur_src_ff [N_CH];   // Current source.
	logic [ADDR_W-1:0]    cur_dst_ff [N_CH];   // Current destination.
	logic [1:0]           src_cc_ff [N_CH];    // Source location and increment.
	logic [1:0]           dst_cc_ff [N_CH];    // Destination location and increment.
	logic [31:0]          ctl_ff [N_CH];       // Channel control word.
	logic [CNT_W-1:0]     cnt_ff [N_CH];       // Current transfer count.
	ch_state_type         st_ff [N_CH];        // Main state.
	ch_state_type         nxt_st [N_CH];       // Next main state.
	logic                 ack_ff [N_CH];       // Channel acknowledge.
	logic                 int_ff [N_CH];       // Interrupt request pulse.
	logic                 sw_req_ff [N_CH];    // Pending software request.
	logic [N_CH-1:0]      req;                 // Selected request, high active.
	logic [N_CH-1:0]      want;                // Channel asks the engine.
	logic [N_CH-1:0]      last;                // Count is one.
	logic [N_CH-1:0]      done_ff;             // Atomic operation finished.
	eng_state_type        eng_ff;              // Engine state.
	logic [1:0]           sel_ff;              // Channel being served.
	logic [1:0]           beat_ff;             // Beat within chunk.
	logic [31:0]          buf_ff [BURST_LEN];  // Read data held for writes.
	logic [1:0]           pick;                // Arbiter winner.
	logic                 any;                 // Some channel waits.
	logic [1:0]           last_beat;           // Final beat index.
	logic [31:0]          s_ctl;               // Control word of served channel.
	logic [1:0]           av_ch;               // Addressed channel.
	logic [4:0]           av_reg;              // Addressed register.

	assign av_ch = AVS_ADDRESS[AV_AW-1:CH_LSB];
	assign av_reg = AVS_ADDRESS[CH_LSB-1:0];
	assign s_ctl = ctl_ff[sel_ff];
	assign last_beat = s_ctl[CW_BURST] ? 2'(BURST_LEN - 1) : 2'h0;

	// Reset is released through two flops.
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// External request pins pass two flops before any use.
	always_ff @(posedge CLK_SYS or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			xreq_meta_ff <= '1;
			xreq_sync_ff <= '1;
		end
		else
		begin
			xreq_meta_ff <= XREQ_N;
			xreq_sync_ff <= xreq_meta_ff;
		end
	end

	// Slave answers one cycle after a request appears.
	always_ff @(posedge CLK_SYS or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			wait_ff <= 1'b1;
		else
			wait_ff <= !((AVS_READ || AVS_WRITE) && wait_ff);
	end

	// Read data is latched while waitrequest is still high.
	always_ff @(posedge CLK_SYS or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			rdata_ff <= RST_WORD;
		else if (AVS_READ && wait_ff)
		begin
			if (av_reg == OFS_SRC)
				rdata_ff <= {1'b0, src_start_ff[av_ch]};
			else if (av_reg == OFS_SRC_CC)
				rdata_ff <= {30'h0, src_cc_ff[av_ch]};
			else if (av_reg == OFS_DST)
				rdata_ff <= {1'b0, dst_start_ff[av_ch]};
			else if (av_reg == OFS_DST_CC)
				rdata_ff <= {30'h0, dst_cc_ff[av_ch]};
			else if (av_reg == OFS_CTL)
				rdata_ff <= ctl_ff[av_ch];
			else if (av_reg == OFS_STAT)
				rdata_ff <= {ack_ff[av_ch], 8'h00, 3'(st_ff[av_ch]), cnt_ff[av_ch]};
			else if (av_reg == OFS_CUR_SRC)
				rdata_ff <= {1'b0, cur_src_ff[av_ch]};
			else if (av_reg == OFS_CUR_DST)
				rdata_ff <= {1'b0, cur_dst_ff[av_ch]};
			else
				rdata_ff <= RST_WORD; // Unaligned offsets read zero.
		end
	end

	assign AVS_READDATA = rdata_ff;
	assign AVS_WAITREQUEST = wait_ff;

	// Fixed priority: lowest channel number wins the engine.
	always_comb
	begin
		pick = 2'h0;
		any = 1'b0;
		for (int i = N_CH - 1; i >= 0; i--)
		begin
			if (want[i])
			begin
				pick = 2'(i);
				any = 1'b1;
			end
		end
	end

	// Shared engine moves one chunk: all reads, then all writes.
	always_ff @(posedge CLK_SYS or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			eng_ff <= ENG_IDLE;
			sel_ff <= 2'h0;
			beat_ff <= 2'h0;
			done_ff <= '0;
			BUS_REQ <= 1'b0;
			M_READ <= 1'b0;
			M_WRITE <= 1'b0;
			M_ADDR <= RST_WORD;
			M_LOC <= 1'b0;
			M_SIZE <= 2'h0;
			M_WDATA <= RST_WORD;
		end
		else
		begin
			done_ff <= '0;
			case (eng_ff)
			ENG_IDLE:
				if (any)
				begin
					sel_ff <= pick;
					BUS_REQ <= 1'b1;
					eng_ff <= ENG_BREQ;
				end
			ENG_BREQ:
				// Nothing moves until ownership is granted.
				if (BUS_GNT)
				begin
					M_READ <= 1'b1;
					beat_ff <= 2'h0;
					M_ADDR <= beat_addr(cur_src_ff[sel_ff], 2'h0, s_ctl[CW_DSIZE +: 2]);
					M_LOC <= src_cc_ff[sel_ff][CC_LOC];
					M_SIZE <= s_ctl[CW_DSIZE +: 2];
					eng_ff <= ENG_RD;
				end
			ENG_RD:
				if (!M_WAIT)
				begin
					if (beat_ff == last_beat)
					begin
						M_READ <= 1'b0;
						M_WRITE <= 1'b1;
						beat_ff <= 2'h0;
						M_ADDR <= beat_addr(cur_dst_ff[sel_ff], 2'h0, s_ctl[CW_DSIZE +: 2]);
						M_LOC <= dst_cc_ff[sel_ff][CC_LOC];
						M_WDATA <= (beat_ff == 2'h0) ? M_RDATA : buf_ff[0];
						eng_ff <= ENG_WR;
					end
					else
					begin
						beat_ff <= beat_ff + 2'h1;
						M_ADDR <= beat_addr(cur_src_ff[sel_ff], beat_ff + 2'h1,
							s_ctl[CW_DSIZE +: 2]);
					end
				end
			ENG_WR:
				if (!M_WAIT)
				begin
					if (beat_ff == last_beat)
					begin
						// Bus is released only after the final write.
						M_WRITE <= 1'b0;
						BUS_REQ <= 1'b0;
						done_ff[sel_ff] <= 1'b1;
						eng_ff <= ENG_IDLE;
					end
					else
					begin
						beat_ff <= beat_ff + 2'h1;
						M_ADDR <= beat_addr(cur_dst_ff[sel_ff], beat_ff + 2'h1,
							s_ctl[CW_DSIZE +: 2]);
						M_WDATA <= buf_ff[beat_ff + 2'h1];
					end
				end
			default:
				eng_ff <= ENG_IDLE;
			endcase
		end
	end

	// Read beats are kept for the write phase.
	always_ff @(posedge CLK_SYS)
	begin
		if (eng_ff == ENG_RD && !M_WAIT)
			buf_ff[beat_ff] <= M_RDATA;
	end

	bus_held_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
		(eng_ff == ENG_RD || eng_ff == ENG_WR) |-> BUS_REQ)
		else $error("Bus request dropped inside a chunk.");
	grant_wait_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
		(eng_ff == ENG_BREQ && !BUS_GNT) |=> (!M_READ && !M_WRITE))
		else $error("Bus access before grant.");
	burst_turn_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
		(eng_ff == ENG_RD && !M_WAIT && beat_ff == last_beat)
		|=> (M_WRITE && !M_READ && beat_ff == 2'h0))
		else $error("Write phase did not follow the last read.");
	burst_move_c : cover property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
		(eng_ff == ENG_WR && s_ctl[CW_BURST] && beat_ff == 2'h3 && !M_WAIT));

	// One main state machine per channel.
	for (genvar c = 0; c < N_CH; c++)
	begin : g_ch
		logic [N_SRC-1:0] srcs; // Request sources, high active.
		logic             wr_hit; // Register write to this channel.

		if (c < N_EXT)
		begin : g_ext
			// Source zero of these channels is the external pin.
			assign srcs = {HW_REQ[c*N_SRC+1 +: N_SRC-1], ~xreq_sync_ff[c]};
		end
		else
		begin : g_int
			assign srcs = HW_REQ[c*N_SRC +: N_SRC];
		end

		// Hardware mode picks one source; software mode ignores the selection.
		assign req[c] = ctl_ff[c][CW_HW] ? srcs[ctl_ff[c][CW_SEL +: SEL_W]]
			: sw_req_ff[c];
		assign want[c] = (st_ff[c] == CH_XFER) && !done_ff[c];
		assign last[c] = (cnt_ff[c] == CNT_W'(1));
		assign wr_hit = AVS_WRITE && !wait_ff && (av_ch == 2'(c));
		assign ACK[c] = ack_ff[c];
		assign INT_REQ[c] = int_ff[c];

		// Next state follows the service and protocol modes.
		always_comb
		begin
			nxt_st[c] = st_ff[c];
			case (st_ff[c])
			CH_IDLE:
				if (req[c])
					nxt_st[c] = CH_LOAD;
			CH_LOAD:
				nxt_st[c] = CH_XFER;
			CH_XFER:
				// The synced request is looked at as each chunk ends.
				if (done_ff[c])
				begin
					if (ctl_ff[c][CW_HW] && ctl_ff[c][CW_HSK])
						nxt_st[c] = CH_HSK;
					else if (last[c])
						nxt_st[c] = CH_END;
					else if (!ctl_ff[c][CW_WHOLE])
						nxt_st[c] = CH_IDLE;
					else if (req[c] || !ctl_ff[c][CW_HW])
						nxt_st[c] = CH_XFER;
					else
						nxt_st[c] = CH_WAIT;
				end
			CH_WAIT:
				if (req[c])
					nxt_st[c] = CH_XFER;
			CH_HSK:
				if (!req[c])
					nxt_st[c] = CH_IDLE;
			default:
				nxt_st[c] = CH_IDLE;
			endcase
		end

		// Software writes to the channel window; a trigger set beats its clear.
		always_ff @(posedge CLK_SYS or negedge rst_n_ff)
		begin
			if (!rst_n_ff)
			begin
				src_start_ff[c] <= '0;
				dst_start_ff[c] <= '0;
				src_cc_ff[c] <= 2'h0;
				dst_cc_ff[c] <= 2'h0;
				ctl_ff[c] <= RST_WORD;
				sw_req_ff[c] <= 1'b0;
			end
			else
			begin
				if (st_ff[c] == CH_LOAD)
					sw_req_ff[c] <= 1'b0;
				if (wr_hit)
				begin
					if (av_reg == OFS_SRC)
						src_start_ff[c] <= AVS_WRITEDATA[ADDR_W-1:0];
					else if (av_reg == OFS_SRC_CC)
						src_cc_ff[c] <= AVS_WRITEDATA[1:0];
					else if (av_reg == OFS_DST)
						dst_start_ff[c] <= AVS_WRITEDATA[ADDR_W-1:0];
					else if (av_reg == OFS_DST_CC)
						dst_cc_ff[c] <= AVS_WRITEDATA[1:0];
					else if (av_reg == OFS_CTL)
						ctl_ff[c] <= AVS_WRITEDATA;
					else if (av_reg == OFS_STAT && AVS_WRITEDATA[ST_SWREQ])
						sw_req_ff[c] <= 1'b1;
				end
			end
		end

		// State, acknowledge, interrupt, count and current addresses.
		always_ff @(posedge CLK_SYS or negedge rst_n_ff)
		begin
			if (!rst_n_ff)
			begin
				st_ff[c] <= CH_IDLE;
				ack_ff[c] <= 1'b0;
				int_ff[c] <= 1'b0;
				cnt_ff[c] <= '0;
				cur_src_ff[c] <= '0;
				cur_dst_ff[c] <= '0;
			end
			else
			begin
				st_ff[c] <= nxt_st[c];
				ack_ff[c] <= (nxt_st[c] != CH_IDLE) && (nxt_st[c] != CH_END);
				int_ff[c] <= done_ff[c] && last[c] && ctl_ff[c][CW_INTEN];
				if (st_ff[c] == CH_LOAD)
				begin
					if (cnt_ff[c] == '0)
						cnt_ff[c] <= ctl_ff[c][CNT_W-1:0];
					if (cur_src_ff[c] == '0)
						cur_src_ff[c] <= src_start_ff[c];
					if (cur_dst_ff[c] == '0)
						cur_dst_ff[c] <= dst_start_ff[c];
				end
				if (done_ff[c])
				begin
					cnt_ff[c] <= cnt_ff[c] - CNT_W'(1);
					if (last[c])
					begin
						// Clearing lets the next job copy its start addresses.
						cur_src_ff[c] <= '0;
						cur_dst_ff[c] <= '0;
					end
					else
					begin
						// Fixed addresses return to their first value.
						if (!src_cc_ff[c][CC_INC])
							cur_src_ff[c] <= cur_src_ff[c] + chunk_bytes(ctl_ff[c]);
						if (!dst_cc_ff[c][CC_INC])
							cur_dst_ff[c] <= cur_dst_ff[c] + chunk_bytes(ctl_ff[c]);
					end
				end
			end
		end

		if (c < N_EXT)
		begin : g_xack
			// External acknowledge is low active and follows the channel.
			always_ff @(posedge CLK_SYS or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
					XACK_N[c] <= 1'b1;
				else
					XACK_N[c] <= (nxt_st[c] == CH_IDLE) || (nxt_st[c] == CH_END);
			end
		end

		idle_quiet_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(st_ff[c] == CH_IDLE) |-> (!ack_ff[c] && !int_ff[c]))
			else $error("Idle channel shows acknowledge or interrupt.");
		load_count_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(st_ff[c] == CH_LOAD && cnt_ff[c] == '0)
			|-> ack_ff[c] ##1 (cnt_ff[c] == $past(ctl_ff[c][CNT_W-1:0])))
			else $error("Counter not loaded in load state.");
		count_step_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			done_ff[c] |=> (cnt_ff[c] == $past(cnt_ff[c]) - CNT_W'(1)))
			else $error("Counter did not step down by one.");
		int_cause_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			int_ff[c] |-> (cnt_ff[c] == '0 && $past(ctl_ff[c][CW_INTEN])))
			else $error("Interrupt without zero count and enable.");
		single_drop_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(done_ff[c] && !ctl_ff[c][CW_WHOLE] && !(ctl_ff[c][CW_HW] && ctl_ff[c][CW_HSK]))
			|=> (!ack_ff[c] && st_ff[c] != CH_XFER))
			else $error("Single service kept acknowledge.");
		hsk_release_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(st_ff[c] == CH_HSK && !req[c]) |-> ##[1:2] !ack_ff[c])
			else $error("Handshake acknowledge held too long.");
		demand_next_a : assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(done_ff[c] && ctl_ff[c][CW_WHOLE] && ctl_ff[c][CW_HW] && !ctl_ff[c][CW_HSK]
			&& !last[c] && req[c]) |=> (st_ff[c] == CH_XFER && ack_ff[c]))
			else $error("Demand mode did not continue.");
		whole_end_c : cover property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(ctl_ff[c][CW_WHOLE] && int_ff[c]));
		hsk_wait_c : cover property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(st_ff[c] == CH_HSK) ##1 (st_ff[c] == CH_IDLE));
		single_req_c : cover property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
			(done_ff[c] && !ctl_ff[c][CW_WHOLE]));
	end
endmodule : four_channel_bridge_dma

// ### rtl/four_channel_bridge_dma_pkg.sv
package four_channel_bridge_dma_pkg;
	//Contract
	//- Four channels, either bus to either bus.
	//- Start by software, peripheral or external pin.
	//- Hardware mode uses selected source; software ignores it.
	//- Idle holds acknowledge and interrupt low.
	//- Load raises acknowledge and loads counter.
	//- Transfer reads source then writes destination.
	//- Whole service repeats to zero; single once.
	//- Counter decrements after each atomic operation.
	//- Interrupt at zero count when enabled.
	//- Acknowledge drops at zero or single completion.
	//- Single service returns idle after each transfer.
	//- External request passes two-stage synchroniser.
	//- Transfers begin only once bus granted.
	//- Sample synced request after each chunk.
	//- Demand mode continues while request held.
	//- Handshake drops acknowledge within two cycles.
	//- Single is one pair; burst four reads, writes.
	//- Bus ownership held through each chunk.
	//- Start address copied when current zero, acknowledged.
	//- Increment advances; fixed restores after burst.

	// Structure of the engine.
	localparam int N_CH = 4;
	localparam int N_SRC = 8;
	localparam int SEL_W = 3;
	localparam int N_EXT = 2;
	localparam int CNT_W = 20;
	localparam int ADDR_W = 31;
	localparam int BURST_LEN = 4;
	localparam int AV_AW = 7;
	localparam int CH_LSB = 5;

	// Register offsets inside one channel window.
	localparam logic [4:0] OFS_SRC = 5'h00;
	localparam logic [4:0] OFS_SRC_CC = 5'h04;
	localparam logic [4:0] OFS_DST = 5'h08;
	localparam logic [4:0] OFS_DST_CC = 5'h0c;
	localparam logic [4:0] OFS_CTL = 5'h10;
	localparam logic [4:0] OFS_STAT = 5'h14;
	localparam logic [4:0] OFS_CUR_SRC = 5'h18;
	localparam logic [4:0] OFS_CUR_DST = 5'h1c;

	// Field positions of the channel control word and location bits.
	localparam int CW_DSIZE = 20;
	localparam int CW_BURST = 22;
	localparam int CW_WHOLE = 23;
	localparam int CW_HW = 24;
	localparam int CW_HSK = 25;
	localparam int CW_INTEN = 28;
	localparam int CW_SEL = 29;
	localparam int CC_INC = 0;
	localparam int CC_LOC = 1;
	localparam int ST_SWREQ = 0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Channel and engine states.
	typedef enum logic [2:0] {CH_IDLE, CH_LOAD, CH_XFER, CH_WAIT, CH_HSK, CH_END} ch_state_type;
	typedef enum logic [1:0] {ENG_IDLE, ENG_BREQ, ENG_RD, ENG_WR} eng_state_type;
endpackage : four_channel_bridge_dma_pkg

// ### verif/bus_slave_model.sv
`timescale 1ns/1ps
// Memory slave standing on both buses, with a grant and random stalls.
module bus_slave_model (
	// Clock.
	input  wire logic        clk,
	// Ownership handshake.
	input  wire logic        bus_req,
	output logic             bus_gnt,
	// Data beats.
	input  wire logic [31:0] m_addr,
	input  wire logic        m_loc,
	input  wire logic        m_read,
	input  wire logic        m_write,
	input  wire logic [31:0] m_wdata,
	output logic      [31:0] m_rdata,
	output logic             m_wait,
	// Stall control from the bench.
	input  wire logic        slow
);
	logic [31:0] mem [0:127];         // Word store, bus select on top.
	logic [31:0] junk = 32'h5a5a0f0f; // Pattern shown when no beat is served.
	logic [6:0]  idx;                 // Word index of the beat.

	assign idx = {m_loc, m_addr[7:2]};
	// Start idle so the engine never sees an unknown grant.
	initial
	begin
		bus_gnt = 1'b0;
		m_wait = 1'b0;
	end
	// Grant follows the request one cycle late, both when it rises and when it drops.
	always @(posedge clk)
		bus_gnt <= bus_req;
	// Stalls come at random while slow is set; writes land on accepted beats.
	always @(posedge clk)
	begin
		junk <= {junk[30:0], junk[31] ^ junk[21]} ^ 32'h1;
		m_wait <= slow & junk[3];
		if (m_write && !m_wait)
			mem[idx] <= m_wdata;
	end
	// Read data only during an accepted read beat, otherwise a moving pattern.
	assign m_rdata = (m_read && !m_wait) ? mem[idx] : ~junk;
endmodule : bus_slave_model

// ### verif/four_channel_bridge_dma_tb.sv
`timescale 1ns/1ps
// Random-data bench for the four channel engine.
module four_channel_bridge_dma_tb
	import four_channel_bridge_dma_pkg::*;
;
	logic        clk = 1'b0;          // System clock.
	logic        rstn = 1'b0;         // Active-low reset.
	logic [6:0]  adr = 7'h00;         // Register address.
	logic        rd = 1'b0;           // Register read strobe.
	logic        wr = 1'b0;           // Register write strobe.
	logic [31:0] wd = 32'h0;          // Register write data.
	logic [31:0] rdat;                // Register read data.
	logic        wreq;                // Register wait request.
	logic [31:0] hw = 32'h0;          // Peripheral request lines.
	logic [1:0]  xreq_n = 2'h3;       // External request pins, idle high.
	logic [1:0]  xack_n;              // External acknowledge pins.
	logic [3:0]  ack;                 // Channel acknowledges.
	logic [3:0]  irq;                 // Channel interrupt pulses.
	logic [5:0]  mon;                 // Watched levels for bounded waits.
	logic        breq, gnt, mloc, mrd, mwr, mwait;
	logic        slow = 1'b0;         // Stall enable for the slave.
	logic [1:0]  msize;               // Beat size.
	logic [31:0] maddr, mwd, mrdat;   // Beat address and data.
	logic [31:0] seed = 32'he366e1cc; // Random state.
	logic [31:0] st;                  // Last register read.
	logic [31:0] src [8];             // Source words of the current job.
	int          err_total = 0;       // Mismatches.
	int          tests_run = 0;       // Comparisons.
	int          irq_cnt [4] = '{default: 0}; // Interrupt pulses per channel.
	localparam logic [31:0] IDLE_M = 32'h8070_0000; // Acknowledge and state fields.

	always #5 clk = ~clk;
	assign mon = {xack_n, ack};

	four_channel_bridge_dma uut (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .HW_REQ(hw), .XREQ_N(xreq_n), .XACK_N(xack_n),
		.ACK(ack), .INT_REQ(irq), .BUS_REQ(breq), .BUS_GNT(gnt), .M_ADDR(maddr),
		.M_LOC(mloc), .M_SIZE(msize), .M_READ(mrd), .M_WRITE(mwr), .M_WDATA(mwd),
		.M_RDATA(mrdat), .M_WAIT(mwait));
	bus_slave_model u_mem (.clk(clk), .bus_req(breq), .bus_gnt(gnt), .m_addr(maddr),
		.m_loc(mloc), .m_read(mrd), .m_write(mwr), .m_wdata(mwd), .m_rdata(mrdat),
		.m_wait(mwait), .slow(slow));

	// Next xorshift value.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// Control word with word size and interrupt enable; m is {hsk,hw,whole,burst}.
	function automatic logic [31:0] cw(input logic [19:0] n, input logic [3:0] m,
		input logic [2:0] s);
		return {s, 1'b1, 2'b00, m, 2'h2, n};
	endfunction : cw
	// Verdict and end of run.
	task stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// A wait that ran out ends the run.
	task tmo();
		err_total++;
		$display("ERROR at %0t: wait ran out", $time);
		stop_test();
	endtask : tmo
	// Compare seen against expected.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : check
	// One register access held until wait request is seen low.
	task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		// Waitrequest and read data are taken at the rising edge only.
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (wreq === 1'b0)
				break;
		end
		if (i == 50)
			tmo();
		st = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	// Wait until a watched level is reached, counting falling edges.
	task await(input int b, input logic v, output int n);
		for (n = 1; n < 100 && mon[b] !== v; n++)
			@(negedge clk);
		if (n == 100)
			tmo();
	endtask : await
	// Wait for a given total of interrupt pulses on a channel.
	task wait_irq(input int c, input int v);
		int i;
		for (i = 0; i < 800 && irq_cnt[c] != v; i++)
			@(negedge clk);
		if (i == 800)
			tmo();
	endtask : wait_irq
	// Poll status until the fields under mask m show the value v.
	task wait_done(input logic [1:0] c, input logic [31:0] m, input logic [31:0] v);
		int i;
		for (i = 0; i < 300; i++)
		begin
			bus(1'b0, {c, OFS_STAT}, 32'h0);
			if (i > 0 && (st & m) === v)
				break;
		end
		if (i == 300)
			tmo();
	endtask : wait_done
	// Fill memory at random and program one channel; sc is {loc, fixed}.
	task job(input logic [1:0] c, input logic [1:0] sc, input logic dl, input logic [31:0] w);
		int i;
		for (i = 0; i < 128; i++)
			u_mem.mem[i] = rnd();
		for (i = 0; i < 8; i++)
			src[i] = u_mem.mem[{sc[1], i[5:0]}];
		slow <= seed[7];
		bus(1'b1, {c, OFS_SRC}, 32'h0);
		bus(1'b1, {c, OFS_SRC_CC}, {30'h0, sc});
		bus(1'b1, {c, OFS_DST}, 32'h40);
		bus(1'b1, {c, OFS_DST_CC}, {30'h0, dl, 1'b0});
		bus(1'b1, {c, OFS_CTL}, w);
	endtask : job
	// Destination words against the source, m is the source repeat length.
	task chk_dst(input logic dl, input int n, input int m);
		int k;
		for (k = 0; k < n; k++)
			check(u_mem.mem[{dl, 6'h10 + k[5:0]}], src[k % m]);
	endtask : chk_dst

	// Count interrupt pulses as they stand for one cycle.
	always @(posedge clk)
		for (int i = 0; i < 4; i++)
			if (irq[i] === 1'b1)
				irq_cnt[i]++;
	// Every beat must be granted and carry the word size.
	always @(posedge clk)
		if (mrd === 1'b1 || mwr === 1'b1)
			check(32'({gnt, msize}), 32'h6);

	// Main sequence.
	initial
	begin
		int n;
		int j;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(32'({ack, irq, xack_n}), 32'h3);
		bus(1'b0, {2'h1, OFS_STAT}, 32'h0);
		check(st, 32'h0);
		bus(1'b0, 7'h03, 32'h0);
		check(st, 32'h0);
		// Whole service by software, system to peripheral bus.
		job(2'h0, 2'b00, 1'b1, cw(20'h3, 4'b0010, 3'h0));
		bus(1'b1, {2'h0, OFS_STAT}, 32'h1);
		wait_done(2'h0, IDLE_M, 32'h0);
		check(st, 32'h0);
		chk_dst(1'b1, 3, 8);
		check(irq_cnt[0], 1);
		// Burst of four, fixed source, peripheral to system bus.
		job(2'h1, 2'b11, 1'b0, cw(20'h2, 4'b0011, 3'h0));
		bus(1'b1, {2'h1, OFS_STAT}, 32'h1);
		wait_done(2'h1, IDLE_M, 32'h0);
		chk_dst(1'b0, 8, 4);
		check(irq_cnt[1], 1);
		// Single service: one transfer per trigger, addresses carry on.
		job(2'h3, 2'b10, 1'b1, cw(20'h2, 4'b0000, 3'h0));
		bus(1'b1, {2'h3, OFS_STAT}, 32'h1);
		wait_done(2'h3, IDLE_M, 32'h0);
		check(st, 32'h1);
		check(irq_cnt[3], 0);
		bus(1'b1, {2'h3, OFS_STAT}, 32'h1);
		wait_done(2'h3, IDLE_M, 32'h0);
		chk_dst(1'b1, 2, 8);
		check(irq_cnt[3], 1);
		// Peripheral request: a foreign line is ignored, the selected one starts.
		j = 16 + int'(rnd() & 32'h7);
		job(2'h2, 2'b00, 1'b0, cw(20'h2, 4'b0110, 3'(j)));
		@(posedge clk);
		hw[j ^ 1] <= 1'b1;
		repeat (20) @(negedge clk);
		check(32'(ack[2]), 32'h0);
		@(posedge clk);
		hw <= 32'h0;
		@(posedge clk);
		hw[j] <= 1'b1;
		await(2, 1'b1, n);
		@(posedge clk);
		hw <= 32'h0;
		// Line gone at the chunk end: the channel waits for a fresh request.
		wait_done(2'h2, 32'h0070_0000, 32'h0030_0000);
		check(st, 32'h8030_0001);
		@(posedge clk);
		hw[j] <= 1'b1;
		@(posedge clk);
		hw <= 32'h0;
		wait_done(2'h2, IDLE_M, 32'h0);
		chk_dst(1'b0, 2, 8);
		check(irq_cnt[2], 1);
		// External demand, whole service: a held request carries on to the next chunk.
		job(2'h0, 2'b00, 1'b0, cw(20'h2, 4'b0110, 3'h0));
		@(posedge clk);
		xreq_n[0] <= 1'b0;
		await(4, 1'b0, n);
		check(32'(n >= 4), 32'h1);
		// Let go during the second chunk so no new job starts after the end.
		wait_done(2'h0, 32'h000f_ffff, 32'h1);
		check(st, 32'h8020_0001);
		xreq_n[0] <= 1'b1;
		wait_irq(0, 2);
		await(4, 1'b1, n);
		chk_dst(1'b0, 2, 8);
		// External handshake: acknowledge waits for the request to go away.
		job(2'h1, 2'b00, 1'b1, cw(20'h1, 4'b1100, 3'h0));
		@(posedge clk);
		xreq_n[1] <= 1'b0;
		await(5, 1'b0, n);
		wait_irq(1, 2);
		repeat (10) @(negedge clk);
		check(32'(xack_n[1]), 32'h0);
		@(posedge clk);
		xreq_n[1] <= 1'b1;
		await(5, 1'b1, n);
		check(32'(n <= 5), 32'h1);
		chk_dst(1'b1, 1, 8);
		stop_test();
	end
endmodule : four_channel_bridge_dma_tb
